// ---- verilog/phy_ctl_pkg.sv ----
// constants for the per-port phy basic control register
// assumes a 16-bit management word and one system clock
package phy_ctl_pkg;
  localparam int  REG_W           = 16;
  localparam int  BIT_SOFT_RESET  = 15;
  localparam int  BIT_LOOPBACK    = 14;
  localparam int  BIT_SPEED       = 13;
  localparam int  BIT_AN_ENABLE   = 12;
  localparam int  BIT_POWER_DOWN  = 11;
  localparam int  BIT_AN_RESTART  = 9;
  localparam int  BIT_DUPLEX      = 8;
  localparam int  BIT_COL_TEST    = 7;
  localparam logic [15:0] WRITABLE_MASK = 16'hF980;
  localparam logic [4:0]  CTL_INDEX     = 5'h00;
  // negotiation stand-in length in cycles
  localparam int  AN_CYCLES       = 16;
  localparam logic [1:0] SYNC_RESET = 2'h0;
  // strap defaults are valid after two sync stages and one register
  localparam int  STRAP_SETTLE    = 3;
endpackage

// ---- verilog/strap_sync.sv ----
// two-flop synchroniser for strap and pin inputs
// assumes one system clock and async active-low reset
`timescale 1ns/1ns
module strap_sync #(
  parameter int W = 3
) (
  input  wire logic         clk_sys_in,
  input  wire logic         rst_n_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] stage1;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_q;

  // first stage feeds only the second
  always_comb begin
    next_stage1 = d_in;
    next_q      = stage1;
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stage1 <= '0;
      q_out  <= '0;
    end else begin
      stage1 <= next_stage1;
      q_out  <= next_q;
    end
  end
endmodule

// ---- verilog/phy_basic_control_reg.sv ----
// per-port phy basic control register, bits 15..0, with strap defaults
// assumes a management front end giving index, write strobe and data
// Summary of operation
// - forced speed bit picks 100 or 10
// - autoneg enable overrides forced speed and duplex
// - power down bit, reset value zero
// - negotiation finish sets status complete flag
// - restart bit self clears, reads zero
// - forced duplex bit picks full or half
// - collision test asserts collision while transmitting
// - speed default is autoneg or speed strap
// - autoneg default is autoneg strap
// - duplex default is not autoneg and duplex strap
// - soft reset restores defaults then clears
// - loopback returns fabric transmit to receive
// - loader rewrites whole register after reset/reload
`timescale 1ns/1ns
module phy_basic_control_reg #(
  parameter int AN_LEN = phy_ctl_pkg::AN_CYCLES
) (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  input  wire logic        autoneg_strap_in,
  input  wire logic        speed_strap_in,
  input  wire logic        duplex_strap_in,
  input  wire logic [4:0]  reg_index_in,
  input  wire logic        reg_write_in,
  input  wire logic [15:0] reg_wdata_in,
  output logic      [15:0] reg_rdata_out,
  input  wire logic        loader_write_in,
  input  wire logic [15:0] loader_data_in,
  input  wire logic        fabric_tx_en_in,
  output logic             fabric_rx_loop_out,
  output logic             fabric_col_out,
  output logic             line_tx_en_out,
  output logic             link_speed_100_out,
  output logic             link_full_duplex_out,
  output logic             autoneg_active_out,
  output logic             phy_power_down_out,
  output logic             autoneg_complete_out
);
  typedef enum logic [1:0] {
    ST_STRAP = 2'b00,
    ST_RUN   = 2'b01,
    ST_NEG   = 2'b11
  } ctl_state_t;

  logic [2:0]  straps;
  logic [15:0] ctl;
  logic [15:0] next_ctl;
  logic [15:0] strap_default;
  logic [15:0] next_strap_default;
  ctl_state_t  state;
  ctl_state_t  next_state;
  logic [15:0] an_count;
  logic [15:0] next_an_count;
  logic        an_done;
  logic        next_an_done;
  logic        next_col;
  logic        next_loop;
  logic        next_line_tx;
  logic        host_wr;
  logic [1:0]  settle;
  logic [1:0]  next_settle;

  // straps come from pins, so they are synchronised first
  strap_sync #(
    .W(3)
  ) u_strap_sync (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .d_in       ({autoneg_strap_in, speed_strap_in, duplex_strap_in}),
    .q_out      (straps)
  );

  assign host_wr = reg_write_in && (reg_index_in == phy_ctl_pkg::CTL_INDEX);

  // strap defaults, tracked from the synchronised straps
  always_comb begin
    next_strap_default = '0;
    next_strap_default[phy_ctl_pkg::BIT_SPEED] =
      straps[2] | straps[1];
    next_strap_default[phy_ctl_pkg::BIT_AN_ENABLE] = straps[2];
    next_strap_default[phy_ctl_pkg::BIT_DUPLEX] =
      ~straps[2] & straps[0];
  end

  // control register next value
  always_comb begin
    next_ctl = ctl;
    // restart bit is never stored; it acts straight from the write data
    next_ctl[phy_ctl_pkg::BIT_AN_RESTART] = 1'b0;
    next_ctl[phy_ctl_pkg::BIT_SOFT_RESET] = 1'b0;
    next_state  = state;
    next_settle = settle;
    case (state)
      ST_STRAP: begin
        // hold until synced straps have reached the default register
        next_ctl = strap_default;
        if (settle == 2'(phy_ctl_pkg::STRAP_SETTLE)) begin
          next_state = ST_RUN;
        end else begin
          next_settle = settle + 2'h1;
        end
      end
      ST_RUN, ST_NEG: begin
        // neg marks a stand-in negotiation still in progress
        if (ctl[phy_ctl_pkg::BIT_AN_ENABLE] &&
            !ctl[phy_ctl_pkg::BIT_POWER_DOWN] && !an_done) begin
          next_state = ST_NEG;
        end else begin
          next_state = ST_RUN;
        end
        if (loader_write_in) begin
          next_ctl = loader_data_in & phy_ctl_pkg::WRITABLE_MASK;
          // soft reset is a command, never a stored loader bit
          next_ctl[phy_ctl_pkg::BIT_SOFT_RESET] = 1'b0;
        end else if (host_wr) begin
          if (reg_wdata_in[phy_ctl_pkg::BIT_SOFT_RESET]) begin
            next_ctl = strap_default;
          end else begin
            // reserved bits never stored
            next_ctl = reg_wdata_in & phy_ctl_pkg::WRITABLE_MASK;
            next_ctl[phy_ctl_pkg::BIT_AN_RESTART] = 1'b0;
          end
        end
      end
      default: begin
        next_state = ST_STRAP;
      end
    endcase
  end

  // negotiation stand-in: counts while enabled and powered, then completes
  always_comb begin
    next_an_count = an_count;
    next_an_done  = an_done;
    if (!ctl[phy_ctl_pkg::BIT_AN_ENABLE] ||
        ctl[phy_ctl_pkg::BIT_POWER_DOWN]) begin
      next_an_count = '0;
      next_an_done  = 1'b0;
    end else if (host_wr && reg_wdata_in[phy_ctl_pkg::BIT_AN_RESTART]) begin
      next_an_count = '0;
      next_an_done  = 1'b0;
    end else if (!an_done) begin
      if (an_count == 16'(AN_LEN - 1)) begin
        next_an_done = 1'b1;
      end else begin
        next_an_count = an_count + 16'h0001;
      end
    end
    // nothing counts until the strap defaults are in place
    if (state == ST_STRAP) begin
      next_an_count = '0;
      next_an_done  = 1'b0;
    end
  end

  // datapath: loopback and collision test
  always_comb begin
    next_loop    = ctl[phy_ctl_pkg::BIT_LOOPBACK] & fabric_tx_en_in;
    next_line_tx = ~ctl[phy_ctl_pkg::BIT_LOOPBACK] & fabric_tx_en_in &
                   ~ctl[phy_ctl_pkg::BIT_POWER_DOWN];
    next_col     = ctl[phy_ctl_pkg::BIT_COL_TEST] & fabric_tx_en_in;
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctl                <= '0;
      strap_default      <= '0;
      state              <= ST_STRAP;
      settle             <= phy_ctl_pkg::SYNC_RESET;
      an_count           <= '0;
      an_done            <= 1'b0;
      fabric_rx_loop_out <= 1'b0;
      line_tx_en_out     <= 1'b0;
      fabric_col_out     <= 1'b0;
    end else begin
      ctl                <= next_ctl;
      strap_default      <= next_strap_default;
      state              <= next_state;
      settle             <= next_settle;
      an_count           <= next_an_count;
      an_done            <= next_an_done;
      fabric_rx_loop_out <= next_loop;
      line_tx_en_out     <= next_line_tx;
      fabric_col_out     <= next_col;
    end
  end

  // read path: reserved and self-clearing bits read zero
  assign reg_rdata_out = ctl & phy_ctl_pkg::WRITABLE_MASK;
  // forced settings only count with negotiation off
  assign link_speed_100_out = ctl[phy_ctl_pkg::BIT_AN_ENABLE] ? an_done :
                              ctl[phy_ctl_pkg::BIT_SPEED];
  assign link_full_duplex_out = ctl[phy_ctl_pkg::BIT_AN_ENABLE] ? an_done :
                                ctl[phy_ctl_pkg::BIT_DUPLEX];
  assign autoneg_active_out = ctl[phy_ctl_pkg::BIT_AN_ENABLE];
  assign phy_power_down_out = ctl[phy_ctl_pkg::BIT_POWER_DOWN];
  assign autoneg_complete_out = an_done;

  property p_col_test;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    ctl[phy_ctl_pkg::BIT_COL_TEST] && fabric_tx_en_in |=> fabric_col_out;
  endproperty
  a_col_test: assert property (p_col_test)
    else $error("collision not shown in test mode");

  property p_restart_zero;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    reg_rdata_out[phy_ctl_pkg::BIT_AN_RESTART] == 1'b0;
  endproperty
  a_restart_zero: assert property (p_restart_zero)
    else $error("restart bit read as one");

  property p_reserved_zero;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (reg_rdata_out & ~phy_ctl_pkg::WRITABLE_MASK) == 16'h0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bits read nonzero");

  property p_forced_speed;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    !ctl[phy_ctl_pkg::BIT_AN_ENABLE] |->
      link_speed_100_out == ctl[phy_ctl_pkg::BIT_SPEED];
  endproperty
  a_forced_speed: assert property (p_forced_speed)
    else $error("forced speed not applied");

  property p_forced_duplex;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    !ctl[phy_ctl_pkg::BIT_AN_ENABLE] |->
      link_full_duplex_out == ctl[phy_ctl_pkg::BIT_DUPLEX];
  endproperty
  a_forced_duplex: assert property (p_forced_duplex)
    else $error("forced duplex not applied");

  property p_loop_blocks_line;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    ctl[phy_ctl_pkg::BIT_LOOPBACK] && fabric_tx_en_in |=>
      fabric_rx_loop_out && !line_tx_en_out;
  endproperty
  a_loop_blocks_line: assert property (p_loop_blocks_line)
    else $error("loopback leaked to line");

  property p_strap_load;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    state == ST_STRAP |=> ctl == $past(strap_default);
  endproperty
  a_strap_load: assert property (p_strap_load)
    else $error("strap default not loaded");

  property p_loader;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    loader_write_in && state != ST_STRAP |=>
      reg_rdata_out == ($past(loader_data_in) & phy_ctl_pkg::WRITABLE_MASK &
                        ~(16'h0001 << phy_ctl_pkg::BIT_SOFT_RESET));
  endproperty
  a_loader: assert property (p_loader)
    else $error("loader value not taken");

  property p_soft_reset_zero;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    reg_rdata_out[phy_ctl_pkg::BIT_SOFT_RESET] == 1'b0;
  endproperty
  a_soft_reset_zero: assert property (p_soft_reset_zero)
    else $error("soft reset bit read as one");

  property p_host_write;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    host_wr && !loader_write_in && state != ST_STRAP &&
      !reg_wdata_in[phy_ctl_pkg::BIT_SOFT_RESET] |=>
      reg_rdata_out == ($past(reg_wdata_in) & phy_ctl_pkg::WRITABLE_MASK);
  endproperty
  a_host_write: assert property (p_host_write)
    else $error("host write not stored as masked");

  property p_soft_reset_load;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    host_wr && !loader_write_in && state != ST_STRAP &&
      reg_wdata_in[phy_ctl_pkg::BIT_SOFT_RESET] |=>
      ctl == $past(strap_default);
  endproperty
  a_soft_reset_load: assert property (p_soft_reset_load)
    else $error("soft reset did not restore defaults");

  property p_autoneg_override;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    ctl[phy_ctl_pkg::BIT_AN_ENABLE] |->
      link_speed_100_out == an_done && link_full_duplex_out == an_done;
  endproperty
  a_autoneg_override: assert property (p_autoneg_override)
    else $error("forced bits leaked while negotiating");

  property p_an_gated;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    !ctl[phy_ctl_pkg::BIT_AN_ENABLE] || ctl[phy_ctl_pkg::BIT_POWER_DOWN]
      |=> !autoneg_complete_out;
  endproperty
  a_an_gated: assert property (p_an_gated)
    else $error("negotiation complete while off or powered down");

  property p_an_complete;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    state != ST_STRAP && ctl[phy_ctl_pkg::BIT_AN_ENABLE] &&
      !ctl[phy_ctl_pkg::BIT_POWER_DOWN] && !an_done &&
      an_count == 16'(AN_LEN - 1) &&
      !(host_wr && reg_wdata_in[phy_ctl_pkg::BIT_AN_RESTART]) |=>
      autoneg_complete_out;
  endproperty
  a_an_complete: assert property (p_an_complete)
    else $error("negotiation did not complete in time");

  property p_restart_clears;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    state != ST_STRAP && host_wr &&
      reg_wdata_in[phy_ctl_pkg::BIT_AN_RESTART] |=> !autoneg_complete_out;
  endproperty
  a_restart_clears: assert property (p_restart_clears)
    else $error("restart did not clear completion");

  property p_power_down_line;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    ctl[phy_ctl_pkg::BIT_POWER_DOWN] |=> !line_tx_en_out;
  endproperty
  a_power_down_line: assert property (p_power_down_line)
    else $error("line transmit during power down");
endmodule

// ---- tb/mgmt_host.sv ----
// management host model writing the basic control word
// assumes writes are sampled on the rising edge of clk_sys_in
`timescale 1ns/1ns
module mgmt_host (
  input  wire logic   clk_sys_in,
  output logic [4:0]  reg_index_out,
  output logic        reg_write_out,
  output logic [15:0] reg_wdata_out
);
  initial begin
    reg_index_out = 5'h00;
    reg_write_out = 1'b0;
    reg_wdata_out = 16'h0000;
  end
  // one-cycle strobe, launched and dropped at falling edges
  task automatic put(input logic [15:0] d);
    @(negedge clk_sys_in);
    reg_index_out = phy_ctl_pkg::CTL_INDEX;
    reg_write_out = 1'b1;
    reg_wdata_out = d;
    @(negedge clk_sys_in);
    reg_write_out = 1'b0;
  endtask
  // autoneg is dropped before power-down goes up
  task automatic wr(input logic [15:0] d);
    if (d[11])
      put(d & 16'hE7FF);
    if (d[7])
      d[14] = 1'b1; // test collisions only looped back
    put(d);
  endtask
endmodule

// ---- tb/testbench.sv ----
// self-checking bench for the phy basic control register
// assumes the host model above and a short negotiation time
`timescale 1ns/1ns
module testbench;
  logic        clk_sys_in = 1'b0;
  logic        rst_n_in   = 1'b0;
  logic        an_s = 1'b0, sp_s = 1'b0, dp_s = 1'b0, tx = 1'b0;
  logic        ld_wr = 1'b0;
  logic [15:0] ld_d = 16'h0000, d, rd;
  logic [4:0]  idx;
  logic [15:0] wd;
  logic        wr, lp, col, line, spd, fdx, ana, pd, anc;
  logic [31:0] seed = 32'h00000049;
  int          n_fail = 0;
  int          checked = 0;

  // 250 MHz system clock
  always #2 clk_sys_in = ~clk_sys_in;

  mgmt_host mgmt_host_inst (.clk_sys_in(clk_sys_in), .reg_index_out(idx),
    .reg_write_out(wr), .reg_wdata_out(wd));
  phy_basic_control_reg #(.AN_LEN(4)) phy_basic_control_reg_inst (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .autoneg_strap_in(an_s), .speed_strap_in(sp_s),
    .duplex_strap_in(dp_s), .reg_index_in(idx), .reg_write_in(wr),
    .reg_wdata_in(wd), .reg_rdata_out(rd), .loader_write_in(ld_wr),
    .loader_data_in(ld_d), .fabric_tx_en_in(tx),
    .fabric_rx_loop_out(lp), .fabric_col_out(col),
    .line_tx_en_out(line), .link_speed_100_out(spd),
    .link_full_duplex_out(fdx), .autoneg_active_out(ana),
    .phy_power_down_out(pd), .autoneg_complete_out(anc));

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [15:0] dflt(input logic a, s, x);
    return {2'h0, a | s, a, 3'h0, ~a & x, 8'h00};
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // straps stay put across the whole reset, well past two edges
  task automatic do_reset();
    @(negedge clk_sys_in);
    rst_n_in = 1'b0;
    repeat (16) @(negedge clk_sys_in);
    rst_n_in = 1'b1;
    repeat (4) @(negedge clk_sys_in);
  endtask

  // main sequence
  initial begin
    for (int i = 0; i < 8; i++) begin
      {an_s, sp_s, dp_s} = i[2:0];
      do_reset();
      chk(rd, dflt(an_s, sp_s, dp_s));
    end
    $display("strap defaults done");
    for (int i = 0; i < 40; i++) begin
      seed = xorshift(seed);
      d = seed[15:0] & 16'h7FFF;
      if (d[11])
        d[12] = 1'b0;
      if (d[7])
        d[14] = 1'b1;
      tx = seed[16];
      mgmt_host_inst.wr(d);
      @(negedge clk_sys_in);
      chk(rd, d & 16'h7980);
      if (!d[12])
        chk({12'h000, spd, fdx, ana, pd},
            {12'h000, d[13], d[8], 1'b0, d[11]});
      chk({15'h0000, line}, {15'h0000, tx & ~d[14] & ~d[11]});
      if (!d[11])
        chk({14'h0000, lp, col}, {14'h0000, tx & d[14], tx & d[7]});
    end
    $display("random writes done");
    mgmt_host_inst.wr(16'h2100);
    mgmt_host_inst.wr(16'h3000);
    repeat (2) @(negedge clk_sys_in);
    chk({14'h0000, anc, spd}, 16'h0000);
    repeat (6) @(negedge clk_sys_in);
    chk({12'h000, ana, anc, spd, fdx}, 16'h000F);
    mgmt_host_inst.wr(16'h3200);
    chk(rd, 16'h3000);
    repeat (2) @(negedge clk_sys_in);
    chk({15'h0000, anc}, 16'h0000);
    repeat (6) @(negedge clk_sys_in);
    chk({15'h0000, anc}, 16'h0001);
    $display("negotiation done");
    mgmt_host_inst.wr(16'h8180);
    @(negedge clk_sys_in);
    chk(rd, dflt(an_s, sp_s, dp_s));
    ld_d = 16'hFFFF;
    ld_wr = 1'b1;
    @(negedge clk_sys_in);
    ld_wr = 1'b0;
    chk(rd, 16'h7980);
    $display("soft reset and loader done");
    give_verdict();
  end

  // watchdog well beyond the expected run length
  initial begin
    #100000;
    n_fail++;
    give_verdict();
  end
endmodule
